// ===== rtl/tfe_top.v
// Flag and event logic of a 16-bit timer/PWM unit with its own counter.
// Assumes a synchronous register port; read data valid one cycle after read.
`default_nettype none
`include "tfe_regs.vh"

module tfe_top (
   // Clock and reset
   input  wire                    ref_clk_i,
   input  wire                    rst_i,
   // Register port
   input  wire [`TFE_AW-1:0]      addr_i,
   input  wire [`TFE_DW-1:0]      wdata_i,
   input  wire                    wr_i,
   input  wire                    rd_i,
   output reg  [`TFE_DW-1:0]      rdata_o,
   // Capture inputs
   input  wire [`TFE_NCH-1:0]     cap_i,
   // Interrupts
   output reg                     irq_o,
   output reg                     evt_irq_o
);

   reg  [`TFE_DW-1:0]   ctrl_reg;
   reg  [`TFE_DW-1:0]   mod_reg;
   reg  [`TFE_DW-1:0]   cfg_reg [0:`TFE_NCH-1];
   reg  [`TFE_DW-1:0]   val_reg [0:`TFE_NCH-1];
   reg  [`TFE_ST_W-1:0] irqst_reg;
   reg  [`TFE_ST_W-1:0] irqmsk_reg;
   reg  [`TFE_DW-1:0]   cnt_reg;
   reg  [`TFE_DW-1:0]   cnt_next;
   reg                  down_reg;
   reg                  down_next;
   reg                  wrap_evt;
   reg  [`TFE_NCH-1:0]  cap_d_reg;
   wire [`TFE_ST_W-1:0] flags;
   wire [`TFE_ST_W-1:0] evt;
   wire [`TFE_ST_W-1:0] enables;

   wire run   = ctrl_reg[`TFE_CTRL_RUN];
   wire cpm   = ctrl_reg[`TFE_CTRL_CPM];
   wire rd_st = rd_i && (addr_i == `TFE_OFF_STAT);
   wire wr_st = wr_i && (addr_i == `TFE_OFF_STAT);

   // Counter step and wrap detection
   always @* begin
      cnt_next  = cnt_reg;
      down_next = down_reg;
      wrap_evt  = 1'b0;
      if (run) begin
         if (cpm) begin
            if (!down_reg && cnt_reg == mod_reg && mod_reg != `TFE_CNT_ZERO) begin
               // Reversal at the top ends the period
               down_next = 1'b1;
               wrap_evt  = 1'b1;
               cnt_next  = cnt_reg - `TFE_CNT_ONE;
            end else if (down_reg && cnt_reg == `TFE_CNT_ZERO) begin
               down_next = 1'b0;
               cnt_next  = cnt_reg + `TFE_CNT_ONE;
            end else if (down_reg) begin
               cnt_next  = cnt_reg - `TFE_CNT_ONE;
            end else begin
               cnt_next  = cnt_reg + `TFE_CNT_ONE;
            end
         end else begin
            down_next = 1'b0;
            if (mod_reg != `TFE_CNT_ZERO && cnt_reg == mod_reg) begin
               cnt_next = `TFE_CNT_ZERO;
               wrap_evt = 1'b1;
            end else if (cnt_reg == `TFE_CNT_FULL) begin
               cnt_next = `TFE_CNT_ZERO;
               wrap_evt = 1'b1;
            end else begin
               cnt_next = cnt_reg + `TFE_CNT_ONE;
            end
         end
      end
   end

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg  <= `TFE_ZERO16;
         down_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         down_reg <= down_next;
      end
   end

   assign evt[`TFE_ST_WRAP]     = wrap_evt;
   assign enables[`TFE_ST_WRAP] = ctrl_reg[`TFE_CTRL_WIE];

   // Per-channel event detection and flags
   genvar g;
   generate
      for (g = 0; g < `TFE_NCH; g = g + 1) begin : gen_ch
         wire [1:0] mode = cfg_reg[g][`TFE_CFG_MODE_HI:`TFE_CFG_MODE_LO];
         wire [1:0] els  = cfg_reg[g][`TFE_CFG_ELS_HI:`TFE_CFG_ELS_LO];
         wire rise  = cap_i[g] && !cap_d_reg[g];
         wire fall  = !cap_i[g] && cap_d_reg[g];
         wire match = run && (cnt_reg == val_reg[g]);
         reg  hit;
         always @* begin
            hit = 1'b0;
            if (mode == `TFE_MODE_CAPT) begin
               // Edge select picks the trigger
               if (els == `TFE_ELS_RISE)
                  hit = rise;
               else if (els == `TFE_ELS_FALL)
                  hit = fall;
               else if (els == `TFE_ELS_ANY)
                  hit = rise || fall;
            end else begin
               // Compare, edge PWM and centered PWM all flag on every match;
               // in centered mode the counter passes values between zero and the limit twice
               hit = match;
            end
         end
         assign evt[`TFE_ST_CH0+g]     = hit;
         assign enables[`TFE_ST_CH0+g] = cfg_reg[g][`TFE_CFG_CIE];
      end
   endgenerate

   // Separate flag storage, cleared bit by bit
   generate
      for (g = 0; g < `TFE_ST_W; g = g + 1) begin : gen_flag
         tfe_flag u_flag (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .set_i     (evt[g]),
            .rd_i      (rd_st),
            .wr0_i     (wr_st && !wdata_i[g]),
            .flag_o    (flags[g])
         );
      end
   endgenerate

   // Register writes, sticky event status and interrupt outputs
   integer i;
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg   <= `TFE_ZERO16;
         mod_reg    <= `TFE_ZERO16;
         irqst_reg  <= {`TFE_ST_W{1'b0}};
         irqmsk_reg <= {`TFE_ST_W{1'b0}};
         cap_d_reg  <= {`TFE_NCH{1'b0}};
         irq_o      <= 1'b0;
         evt_irq_o  <= 1'b0;
         rdata_o    <= `TFE_ZERO16;
         for (i = 0; i < `TFE_NCH; i = i + 1) begin
            cfg_reg[i] <= `TFE_ZERO16;
            val_reg[i] <= `TFE_ZERO16;
         end
      end else begin
         cap_d_reg <= cap_i;
         if (wr_i) begin
            if (addr_i == `TFE_OFF_CTRL)
               ctrl_reg <= wdata_i;
            else if (addr_i == `TFE_OFF_MOD)
               mod_reg <= wdata_i;
            else if (addr_i == `TFE_OFF_CH0CFG)
               cfg_reg[0] <= wdata_i;
            else if (addr_i == `TFE_OFF_CH1CFG)
               cfg_reg[1] <= wdata_i;
            else if (addr_i == `TFE_OFF_CH0VAL)
               val_reg[0] <= wdata_i;
            else if (addr_i == `TFE_OFF_CH1VAL)
               val_reg[1] <= wdata_i;
            else if (addr_i == `TFE_OFF_IRQMSK)
               irqmsk_reg <= wdata_i[`TFE_ST_W-1:0];
         end
         // Read clears, but a same-cycle event still wins
         if (rd_i && addr_i == `TFE_OFF_IRQST)
            irqst_reg <= evt;
         else
            irqst_reg <= irqst_reg | evt;
         // Level request while an enabled flag is set
         irq_o     <= |(flags & enables);
         evt_irq_o <= |(irqst_reg & irqmsk_reg);
         rdata_o   <= `TFE_ZERO16;
         if (rd_i) begin
            if (addr_i == `TFE_OFF_CTRL)
               rdata_o <= ctrl_reg;
            else if (addr_i == `TFE_OFF_MOD)
               rdata_o <= mod_reg;
            else if (addr_i == `TFE_OFF_CH0CFG)
               rdata_o <= cfg_reg[0];
            else if (addr_i == `TFE_OFF_CH1CFG)
               rdata_o <= cfg_reg[1];
            else if (addr_i == `TFE_OFF_CH0VAL)
               rdata_o <= val_reg[0];
            else if (addr_i == `TFE_OFF_CH1VAL)
               rdata_o <= val_reg[1];
            else if (addr_i == `TFE_OFF_STAT)
               rdata_o <= {{(`TFE_DW-`TFE_ST_W){1'b0}}, flags};
            else if (addr_i == `TFE_OFF_IRQST)
               rdata_o <= {{(`TFE_DW-`TFE_ST_W){1'b0}}, irqst_reg};
            else if (addr_i == `TFE_OFF_IRQMSK)
               rdata_o <= {{(`TFE_DW-`TFE_ST_W){1'b0}}, irqmsk_reg};
            else if (addr_i == `TFE_OFF_COUNT)
               rdata_o <= cnt_reg;
         end
      end
   end

endmodule

`default_nettype wire

// ===== rtl/tfe_regs.vh
// Register map, field layout and constants of the timer flag/event block.
// Assumes a plain register port with 8-bit address and 16-bit data.
`ifndef TFE_REGS_VH
`define TFE_REGS_VH

`define TFE_NCH          2
`define TFE_AW           8
`define TFE_DW           16

// Register offsets
`define TFE_OFF_CTRL     8'h00
`define TFE_OFF_MOD      8'h04
`define TFE_OFF_CH0CFG   8'h08
`define TFE_OFF_CH1CFG   8'h0C
`define TFE_OFF_CH0VAL   8'h10
`define TFE_OFF_CH1VAL   8'h14
`define TFE_OFF_STAT     8'h18
`define TFE_OFF_IRQST    8'h1C
`define TFE_OFF_IRQMSK   8'h20
`define TFE_OFF_COUNT    8'h24

// Control register fields
`define TFE_CTRL_RUN     0
`define TFE_CTRL_CPM     1
`define TFE_CTRL_WIE     2

// Channel config fields
`define TFE_CFG_MODE_LO  0
`define TFE_CFG_MODE_HI  1
`define TFE_CFG_ELS_LO   2
`define TFE_CFG_ELS_HI   3
`define TFE_CFG_CIE      4

// Channel modes
`define TFE_MODE_CAPT    2'h0
`define TFE_MODE_CMP     2'h1
`define TFE_MODE_PWM     2'h2

// Edge select codes
`define TFE_ELS_OFF      2'h0
`define TFE_ELS_RISE     2'h1
`define TFE_ELS_FALL     2'h2
`define TFE_ELS_ANY      2'h3

// Status layout: bit 0 wrap flag, bits 1.. channel flags
`define TFE_ST_WRAP      0
`define TFE_ST_CH0       1
`define TFE_ST_W         3

// Counter values
`define TFE_CNT_ZERO     16'h0000
`define TFE_CNT_ONE      16'h0001
`define TFE_CNT_FULL     16'hFFFF
`define TFE_ZERO16       16'h0000

`endif

// ===== rtl/tfe_flag.v
// One event flag with a read-then-write-zero clear handshake.
// Assumes read and write strobes are one cycle and never coincide.
`default_nettype none

module tfe_flag (
   // Clock and reset
   input  wire ref_clk_i,
   input  wire rst_i,
   // Event and software access
   input  wire set_i,
   input  wire rd_i,
   input  wire wr0_i,
   // State
   output reg  flag_o
);

   reg armed_reg;

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_o    <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         if (set_i) begin
            // A new event restarts the sequence so it is never lost
            flag_o    <= 1'b1;
            armed_reg <= 1'b0;
         end else if (wr0_i && armed_reg) begin
            flag_o    <= 1'b0;
            armed_reg <= 1'b0;
         end else if (rd_i && flag_o) begin
            armed_reg <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ===== test/tfe_checker.sv
// Port checker for tfe_top: register answers, flag reads, interrupt drops.
// Assumes one clock domain; bound to every tfe_top instance below.
`default_nettype none
module tfe_checker (
   // Watched ports
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        irq_o,
   input wire logic        evt_irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rs; rd_i && addr_i == 8'h18; endsequence
   sequence s_w1; wr_i && addr_i == 8'h18 && wdata_i[2:0] == 3'h7; endsequence
   property p_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
   property p_bad; rd_i && addr_i > 8'h24 |=> rdata_o == 16'h0000; endproperty
   property p_wid; s_rs |=> rdata_o[15:3] == 13'h0000; endproperty
   // Flags only rise without a write, so a second read keeps every bit
   property p_keep; s_rs ##1 s_rs |=> (rdata_o & $past(rdata_o)) == $past(rdata_o); endproperty
   property p_w1;
      s_rs ##1 s_w1 ##1 s_rs |=> (rdata_o & $past(rdata_o, 2)) == $past(rdata_o, 2);
   endproperty
   property p_irq; $fell(irq_o) |-> $past(wr_i, 2); endproperty
   property p_evt; $fell(evt_irq_o) |-> $past(wr_i, 2) || $past(rd_i, 2); endproperty
   property p_rb;
      wr_i && (addr_i == 8'h04 || addr_i == 8'h10) ##1 rd_i && addr_i == $past(addr_i)
         |=> rdata_o == $past(wdata_i, 2);
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer cycle");
   a_bad: assert property (p_bad) else $error("unmapped read not zero");
   a_wid: assert property (p_wid) else $error("status spare bits set");
   a_keep: assert property (p_keep) else $error("flag lost without write");
   a_w1: assert property (p_w1) else $error("write of one cleared a flag");
   a_irq: assert property (p_irq) else $error("irq dropped without write");
   a_evt: assert property (p_evt) else $error("event irq dropped alone");
   a_rb: assert property (p_rb) else $error("limit readback wrong");
endmodule
bind tfe_top tfe_checker tfe_checker_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .irq_o(irq_o), .evt_irq_o(evt_irq_o));
`default_nettype wire

// ===== test/tfe_top_tb.sv
// Bench for tfe_top: register port tasks and capture pin stimulus.
// Assumes the map of tfe_regs.vh; counter restarts from zero on reset.
`default_nettype none
`include "tfe_regs.vh"
module tfe_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ST = `TFE_OFF_STAT;
   localparam logic [7:0] CT = `TFE_OFF_CTRL;
   logic        ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, irq_o, evt_irq_o;
   logic [7:0]  addr_i = 0;
   logic [15:0] wdata_i = 0, rdata_o, q;
   logic [1:0]  cap_i = 0;
   int          err_total = 0, checked = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   tfe_top tfe_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_i(cap_i),
      .irq_o(irq_o), .evt_irq_o(evt_irq_o));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus cycle; q takes the answer to the previous cycle's read
   task automatic op(input logic w, r, input logic [7:0] a, input logic [15:0] d);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      @(negedge ref_clk_i);
      q = rdata_o;
      @(posedge ref_clk_i);
   endtask
   task automatic tick(input int n);
      repeat (n) op(0, 0, 0, 0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      op(1, 0, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      op(0, 1, a, 0);
      tick(1);
   endtask
   task automatic clr;
      rd(ST);
      wr(ST, 0);
   endtask
   task automatic rst_pulse;
      rst_i <= 1;
      tick(2);
      rst_i <= 0;
   endtask
   task automatic t_wrap;
      wr(8'h30, 16'hFFFF);
      rd(8'h30);
      chk("unmapped", q, 0);
      wr(`TFE_OFF_MOD, 16'h0008);
      rd(`TFE_OFF_MOD);
      chk("limit", q, 16'h0008);
      wr(CT, 16'h0005);
      tick(20);
      wr(CT, 16'h0004);
      wr(ST, 0);
      tick(3);
      chk("irq", irq_o, 1);
      op(0, 1, ST, 0);
      rd(ST);
      chk("stat", q, 1);
      wr(ST, 0);
      tick(3);
      chk("irq", irq_o, 0);
      rd(ST);
      chk("stat", q, 0);
   endtask
   task automatic t_cmp;
      wr(`TFE_OFF_CH0CFG, 16'h0011);
      wr(`TFE_OFF_CH0VAL, 16'h0003);
      wr(CT, 16'h0001);
      tick(12);
      wr(CT, 16'h0000);
      op(0, 1, ST, 0);
      op(1, 0, ST, 16'h0007);
      rd(ST);
      chk("cmp", q, 3);
      chk("irq", irq_o, 1);
      wr(ST, 16'h0001);
      rd(ST);
      chk("one", q, 1);
      chk("irq", irq_o, 0);
      wr(ST, 0);
      tick(1);
   endtask
   task automatic t_cap;
      for (int c = 0; c < 4; c++) begin
         wr(`TFE_OFF_CH1CFG, 16'(c << 2));
         cap_i <= 2'b11;
         tick(3);
         rd(ST);
         chk("rise", q, {13'h0, c[0], 2'h0});
         wr(ST, 0);
         cap_i <= 2'b00;
         tick(3);
         rd(ST);
         chk("fall", q, {13'h0, c[1], 2'h0});
         clr;
      end
   endtask
   task automatic t_race;
      wr(`TFE_OFF_IRQMSK, 16'h0004);
      rd(`TFE_OFF_IRQST);
      cap_i <= 2'b11;
      tick(4);
      chk("evt", evt_irq_o, 1);
      op(0, 1, ST, 0);
      cap_i <= 2'b00;
      tick(3);
      wr(ST, 0);
      rd(ST);
      chk("race", q, 4);
      rd(`TFE_OFF_IRQST);
      chk("sticky", q, 4);
      tick(1);
      chk("evt", evt_irq_o, 0);
      clr;
      rd(ST);
      chk("clear", q, 0);
   endtask
   // Counts 0..3 up, then 4,3,2,1: one match each way, reversal only in the second
   task automatic t_cpm;
      rst_pulse;
      wr(`TFE_OFF_MOD, 16'h0004);
      wr(`TFE_OFF_CH0CFG, 16'h0002);
      wr(`TFE_OFF_CH0VAL, 16'h0002);
      wr(CT, 16'h0003);
      tick(2);
      wr(CT, 16'h0002);
      rd(ST);
      chk("up", q, 2);
      wr(ST, 0);
      wr(CT, 16'h0003);
      tick(3);
      wr(CT, 16'h0002);
      rd(ST);
      chk("down", q, 3);
   endtask
   task automatic t_free;
      rst_pulse;
      wr(CT, 16'h0001);
      tick(65500);
      rd(ST);
      chk("free", q, 0);
      tick(60);
      rd(ST);
      chk("free", q, 1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 0;
      t_wrap;
      t_cmp;
      t_cap;
      t_race;
      t_cpm;
      t_free;
      stop_test;
   end
   // About 66k cycles are needed; the limit of 87500 cycles at 8 ns leaves about a third more
   initial begin
      #700000;
      err_total++;
      stop_test;
   end
endmodule
`default_nettype wire
